// [core/power_up_config_loader_defines.svh]
// Constants for the power-up sequencer and configuration loader.
`ifndef POWER_UP_CONFIG_LOADER_DEFINES_SVH
`define POWER_UP_CONFIG_LOADER_DEFINES_SVH
`define OSC_DIV_RATIO 4'h8
`define STARTUP_FREQ_HZ 1000000
`define OSC_FREQ_HZ 8000000
`define RESET_FETCH_ADDR 32'h0000_0000
`define FLASH_BASE 32'h0000_0000
`define SRAM_BASE 32'h2000_0000
`define BRIDGE_A_BASE 32'h4000_0000
`define BRIDGE_B_BASE 32'h4100_0000
`define BRIDGE_C_BASE 32'h4200_0000
`define BRIDGE_SPAN 32'h0001_0000
`define SRAM_SPAN 32'h0000_1000
`define FLASH_PAGE_BYTES 32'h0000_0040
`define FLASH_PAGES_LARGE 32'h0000_0100
`define FLASH_PAGES_SMALL 32'h0000_0080
`define USER_ROW_ADDR 32'h0080_4000
`define UR_BOOT_PROTECT_LSB 0
`define UR_EEPROM_LSB 4
`define UR_MBOD_LEVEL_LSB 8
`define UR_MBOD_EN_BIT 14
`define UR_MBOD_ACT_LSB 15
`define UR_CBOD_LSB 17
`define UR_WATCHDOG_EN_BIT 25
`define UR_WATCHDOG_AON_BIT 26
`define UR_WATCHDOG_PER_LSB 27
`define UR_WATCHDOG_WIN_LSB 31
`define UR_WATCHDOG_EWO_LSB 35
`define UR_WATCHDOG_WEN_BIT 39
`define UR_MBOD_HYST_BIT 40
`define UR_CBOD_HI_BIT 41
`define UR_LOCK_LSB 48
`define NUM_GCLK 8
// Slot of the watchdog generic clock among the enables; the value is arbitrary.
`define WATCHDOG_GCLK_IDX 2
`endif

// [core/power_up_config_loader_pkg.sv]
// Types shared by the power-up sequencer files.
package power_up_config_loader_pkg;
  typedef enum logic [2:0] {
    ST_RESET,
    ST_CLK_START,
    ST_LOAD_REQ,
    ST_LOAD_WAIT,
    ST_RUN
  } seq_state_e;
  typedef struct packed {
    logic [2:0] boot_region_protect_size;
    logic [2:0] eeprom_size;
    logic [15:0] region_lock;
  } flash_cfg_s;
  typedef struct packed {
    logic [5:0] level;
    logic enable;
    logic [1:0] action;
    logic hysteresis;
  } mbod_cfg_s;
  typedef struct packed {
    logic enable;
    logic always_on;
    logic window_enable;
    logic [3:0] period;
    logic [3:0] window;
    logic [3:0] early_warning_offset;
  } watchdog_cfg_s;
  typedef struct packed {
    logic [7:0] low_bits;
    logic high_bit;
  } cbod_cfg_s;
  typedef enum logic [2:0] {
    REGION_FLASH,
    REGION_SRAM,
    REGION_BRIDGE_A,
    REGION_BRIDGE_B,
    REGION_BRIDGE_C,
    REGION_USER_ROW,
    REGION_NONE
  } region_e;
endpackage

// [core/fixed_address_decoder.sv]
// Fixed, never remapped address decoder for the high-speed bus matrix.
`timescale 1ns/10ps
`default_nettype none
`include "power_up_config_loader_defines.svh"
module fixed_address_decoder #(
  parameter logic [31:0] FLASH_PAGES = `FLASH_PAGES_LARGE
) (
  input wire logic [31:0] addr_i,
  output logic [2:0] region_o
);
  localparam logic [31:0] FLASH_SPAN = FLASH_PAGES * `FLASH_PAGE_BYTES;

  // Pure combinational decode; no register can move any window.
  always_comb begin
    if (addr_i < `FLASH_BASE + FLASH_SPAN) begin // (R11)
      region_o = power_up_config_loader_pkg::REGION_FLASH; // (R10)
    end else if (addr_i >= `USER_ROW_ADDR && addr_i < `USER_ROW_ADDR + 32'h8) begin
      region_o = power_up_config_loader_pkg::REGION_USER_ROW; // (R14)
    end else if (addr_i >= `SRAM_BASE && addr_i < `SRAM_BASE + `SRAM_SPAN) begin
      region_o = power_up_config_loader_pkg::REGION_SRAM; // (R11)
    end else if (addr_i >= `BRIDGE_A_BASE && addr_i < `BRIDGE_A_BASE + `BRIDGE_SPAN) begin
      region_o = power_up_config_loader_pkg::REGION_BRIDGE_A; // (R11)
    end else if (addr_i >= `BRIDGE_B_BASE && addr_i < `BRIDGE_B_BASE + `BRIDGE_SPAN) begin
      region_o = power_up_config_loader_pkg::REGION_BRIDGE_B; // (R11)
    end else if (addr_i >= `BRIDGE_C_BASE && addr_i < `BRIDGE_C_BASE + `BRIDGE_SPAN) begin
      region_o = power_up_config_loader_pkg::REGION_BRIDGE_C;
    end else begin
      region_o = power_up_config_loader_pkg::REGION_NONE;
    end
  end
endmodule
`default_nettype wire

// [core/power_up_config_loader.sv]
// Power-up sequencer that starts clocks, loads the user row and releases the CPU.
//
// Overview of operation
// (R01) Hold chip reset until the supply-stable flag is seen.
// (R02) After power is stable, divide the 8 MHz oscillator by eight for generator zero.
// (R03) Generator zero clocks the power manager unit after start-up.
// (R04) Running synchronous system clocks are undivided and fed from generator zero.
// (R05) Disable every generic clock at start-up except the watchdog one; the code also leaves generic clock 0 enabled.
// (R06) All I/O pads stay high impedance until configured.
// (R07) CPU fetches initial PC and SP from address zero, start of flash.
// (R08) Supply-on reset stays active always and resets the whole chip.
// (R09) Core-supply brown-out supervision starts only after start-up completes.
// (R10) Bus matrix decodes a fixed map, never remapped, even during boot.
// (R11) Flash at zero, SRAM 0x20000000, bridges 0x40000000 and 0x41000000, 64 KB each.
// (R12) Flash uses 64-byte pages; 256 pages large, 128 pages small variant.
// (R13) User configuration row is read automatically at power-on and distributed.
// (R14) User configuration row is readable by bus at 0x804000.
// (R15) New user row contents take effect only after the next reset.
// (R16) Row bits 2:0 give the boot region protect size to flash control.
// (R17) Row bits 6:4 give the EEPROM emulation area size.
// (R18) Main brown-out level bits 13:8, enable bit 14, action bits 16:15.
// (R19) Main brown-out hysteresis comes from row bit 40.
// (R20) Software rewriting the row keeps bits 24:17 and 41 unchanged.
// (R21) Watchdog enable bit 25, always-on bit 26, window enable bit 39.
// (R22) Watchdog period bits 30:27, window bits 34:31, warning offset bits 38:35.
// (R23) Row bits 63:48 give one flash region lock bit per region.
// (R24) Reserved row bits 3, 7 and 47:42 are ignored and routed nowhere.
`timescale 1ns/10ps
`default_nettype none
`include "power_up_config_loader_defines.svh"
module power_up_config_loader #(
  parameter logic [31:0] FLASH_PAGES = `FLASH_PAGES_LARGE,
  parameter int NUM_PADS = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic internal_8mhz_oscillator_i,
  input wire logic supply_stable_i,
  input wire logic main_supply_below_threshold_i,
  output logic user_row_rd_req_o,
  input wire logic user_row_rd_ack_i,
  input wire logic [63:0] user_row_rd_data_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic bus_rd_i,
  output logic [31:0] bus_rd_data_o,
  output logic [2:0] bus_region_o,
  output logic chip_reset_b_o,
  output logic cpu_reset_b_o,
  output logic [31:0] cpu_reset_addr_o,
  output logic gclk0_o,
  output logic [`NUM_GCLK-1:0] gclk_enable_o,
  output logic power_manager_unit_clk_o,
  output logic [3:0] sys_clk_div_o,
  output logic [NUM_PADS-1:0] pad_oe_o,
  output logic core_supply_brownout_detector_en_o,
  output logic startup_done_o,
  output power_up_config_loader_pkg::flash_cfg_s flash_cfg_o,
  output power_up_config_loader_pkg::mbod_cfg_s mbod_cfg_o,
  output power_up_config_loader_pkg::watchdog_cfg_s watchdog_cfg_o,
  output power_up_config_loader_pkg::cbod_cfg_s cbod_cfg_o,
  output logic [31:0] flash_pages_o,
  output logic [31:0] flash_page_bytes_o
);
  power_up_config_loader_pkg::seq_state_e state_ff, nxt_state;
  logic [1:0] div_cnt_ff;
  logic gclk0_ff;
  logic osc_prev_ff;
  logic [63:0] row_ff;
  logic rd_req_ff;
  logic [31:0] bus_rd_data_ff;
  logic chip_rst_b;

  // The supply-on monitor resets everything, independent of any sleep state.
  assign chip_rst_b = rst_b_i & ~main_supply_below_threshold_i; // (R08)

  // Sequencer: reset, clock start, row load, then run.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      power_up_config_loader_pkg::ST_RESET: begin
        if (supply_stable_i) begin // (R01)
          nxt_state = power_up_config_loader_pkg::ST_CLK_START;
        end
      end
      power_up_config_loader_pkg::ST_CLK_START: begin
        nxt_state = power_up_config_loader_pkg::ST_LOAD_REQ;
      end
      power_up_config_loader_pkg::ST_LOAD_REQ: begin
        nxt_state = power_up_config_loader_pkg::ST_LOAD_WAIT;
      end
      power_up_config_loader_pkg::ST_LOAD_WAIT: begin
        if (user_row_rd_ack_i) begin // (R13)
          nxt_state = power_up_config_loader_pkg::ST_RUN;
        end
      end
      power_up_config_loader_pkg::ST_RUN: begin
        nxt_state = power_up_config_loader_pkg::ST_RUN;
      end
      default: begin
        nxt_state = power_up_config_loader_pkg::ST_RESET;
      end
    endcase
    if (!supply_stable_i) begin
      nxt_state = power_up_config_loader_pkg::ST_RESET; // (R01)
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i) begin
    if (!chip_rst_b) begin
      state_ff <= power_up_config_loader_pkg::ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Divide the oscillator by eight: toggle every fourth rising edge.
  always_ff @(posedge ref_clk_i) begin
    if (!chip_rst_b || state_ff == power_up_config_loader_pkg::ST_RESET) begin
      // Follow the pin level so that leaving reset counts no false edge.
      osc_prev_ff <= internal_8mhz_oscillator_i;
      div_cnt_ff <= 2'h0;
      gclk0_ff <= 1'b0;
    end else begin
      osc_prev_ff <= internal_8mhz_oscillator_i;
      if (internal_8mhz_oscillator_i && !osc_prev_ff) begin
        div_cnt_ff <= div_cnt_ff + 2'h1;
        if (div_cnt_ff == 2'h3) begin
          gclk0_ff <= ~gclk0_ff; // (R02)
        end
      end
    end
  end

  // Row capture happens only in the load phase, so later row writes wait for reset.
  always_ff @(posedge ref_clk_i) begin
    if (!chip_rst_b) begin
      row_ff <= 64'h0;
      rd_req_ff <= 1'b0;
    end else begin
      rd_req_ff <= (nxt_state == power_up_config_loader_pkg::ST_LOAD_WAIT) &&
                   (state_ff != power_up_config_loader_pkg::ST_RUN) && !user_row_rd_ack_i;
      if (state_ff == power_up_config_loader_pkg::ST_LOAD_WAIT && user_row_rd_ack_i) begin
        row_ff <= user_row_rd_data_i; // (R13) (R15)
      end
    end
  end

  // Distribute the captured row fields; reserved bits are not used.
  always_comb begin
    flash_cfg_o.boot_region_protect_size = row_ff[`UR_BOOT_PROTECT_LSB +: 3]; // (R16)
    flash_cfg_o.eeprom_size = row_ff[`UR_EEPROM_LSB +: 3]; // (R17)
    flash_cfg_o.region_lock = row_ff[`UR_LOCK_LSB +: 16]; // (R23)
    mbod_cfg_o.level = row_ff[`UR_MBOD_LEVEL_LSB +: 6]; // (R18)
    mbod_cfg_o.enable = row_ff[`UR_MBOD_EN_BIT]; // (R18)
    mbod_cfg_o.action = row_ff[`UR_MBOD_ACT_LSB +: 2]; // (R18)
    mbod_cfg_o.hysteresis = row_ff[`UR_MBOD_HYST_BIT]; // (R19)
    watchdog_cfg_o.enable = row_ff[`UR_WATCHDOG_EN_BIT]; // (R21)
    watchdog_cfg_o.always_on = row_ff[`UR_WATCHDOG_AON_BIT]; // (R21)
    watchdog_cfg_o.window_enable = row_ff[`UR_WATCHDOG_WEN_BIT]; // (R21)
    watchdog_cfg_o.period = row_ff[`UR_WATCHDOG_PER_LSB +: 4]; // (R22)
    watchdog_cfg_o.window = row_ff[`UR_WATCHDOG_WIN_LSB +: 4]; // (R22)
    watchdog_cfg_o.early_warning_offset = row_ff[`UR_WATCHDOG_EWO_LSB +: 4]; // (R22)
    cbod_cfg_o.low_bits = row_ff[`UR_CBOD_LSB +: 8];
    cbod_cfg_o.high_bit = row_ff[`UR_CBOD_HI_BIT];
  end
  // Bits 3, 7 and 47:42 of row_ff feed no output. (R24)

  // Bus read path; the user row word is returned from the live row input.
  fixed_address_decoder #(
    .FLASH_PAGES(FLASH_PAGES)
  ) i_fixed_address_decoder (
    .addr_i(bus_addr_i),
    .region_o(bus_region_o)
  ); // (R10) (R11)

  // Read data register for the user row window, two words at 0x804000 and 0x804004.
  always_ff @(posedge ref_clk_i) begin
    if (!chip_rst_b) begin
      bus_rd_data_ff <= 32'h0;
    end else if (bus_rd_i &&
                 bus_region_o == power_up_config_loader_pkg::REGION_USER_ROW) begin
      bus_rd_data_ff <= bus_addr_i[2] ? user_row_rd_data_i[63:32]
                                      : user_row_rd_data_i[31:0]; // (R14)
    end else begin
      bus_rd_data_ff <= 32'h0;
    end
  end

  assign bus_rd_data_o = bus_rd_data_ff;
  assign user_row_rd_req_o = rd_req_ff;
  assign chip_reset_b_o = chip_rst_b && state_ff != power_up_config_loader_pkg::ST_RESET; // (R01)
  assign startup_done_o = state_ff == power_up_config_loader_pkg::ST_RUN;
  assign cpu_reset_b_o = startup_done_o;
  assign cpu_reset_addr_o = `RESET_FETCH_ADDR; // (R07)
  assign gclk0_o = gclk0_ff; // (R02)
  assign power_manager_unit_clk_o = gclk0_ff; // (R03)
  assign sys_clk_div_o = 4'h1; // (R04)
  assign pad_oe_o = '0; // (R06)
  assign core_supply_brownout_detector_en_o = startup_done_o; // (R09)
  assign flash_pages_o = FLASH_PAGES; // (R12)
  assign flash_page_bytes_o = `FLASH_PAGE_BYTES; // (R12)

  // Only generator zero and the watchdog clock run after start-up.
  always_comb begin
    gclk_enable_o = '0;
    if (state_ff != power_up_config_loader_pkg::ST_RESET) begin
      gclk_enable_o[0] = 1'b1; // (R03) (R04)
      gclk_enable_o[`WATCHDOG_GCLK_IDX] = 1'b1; // (R05)
    end
  end
endmodule
`default_nettype wire

// [dv/user_row_store.sv]
// Model of the user row store that answers row read requests.
`timescale 1ns/10ps
`default_nettype none
module user_row_store (
  input wire logic ref_clk_i,
  input wire logic req_i,
  input wire logic [3:0] dly_i,
  output logic ack_o
);
  logic [3:0] wait_ff;
  // Counts request cycles so the answer can come promptly or late.
  always_ff @(posedge ref_clk_i) begin
    wait_ff <= req_i ? wait_ff + 4'h1 : 4'h0;
  end
  // The answer is given only while a request is pending.
  assign ack_o = req_i && (wait_ff >= dly_i);
endmodule
`default_nettype wire

// [dv/power_up_config_loader_checker.sv]
// Port checker for the power-up sequencer and its bind.
`timescale 1ns/10ps
`default_nettype none
module power_up_config_loader_checker (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic supply_stable_i,
  input wire logic main_supply_below_threshold_i,
  input wire logic user_row_rd_req_o,
  input wire logic user_row_rd_ack_i,
  input wire logic [63:0] user_row_rd_data_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic bus_rd_i,
  input wire logic [31:0] bus_rd_data_o,
  input wire logic chip_reset_b_o,
  input wire logic cpu_reset_b_o,
  input wire logic [7:0] gclk_enable_o,
  input wire logic gclk0_o,
  input wire logic power_manager_unit_clk_o,
  input wire logic core_supply_brownout_detector_en_o,
  input wire power_up_config_loader_pkg::flash_cfg_s flash_cfg_o
);
  logic [63:0] row_ff;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Keeps the row value seen at each edge for the bus read checks.
  always_ff @(posedge ref_clk_i) begin
    row_ff <= user_row_rd_data_i;
  end
  stable_hold_a: assert property (!supply_stable_i |=> !cpu_reset_b_o && !chip_reset_b_o)
    else $error("cpu left reset without a stable supply");
  supply_reset_a: assert property (main_supply_below_threshold_i |-> !chip_reset_b_o)
    else $error("low supply did not reset the chip");
  mgr_clock_a: assert property (power_manager_unit_clk_o == gclk0_o)
    else $error("power manager clock differs from generator zero");
  gclk_idle_a: assert property ($past(!chip_reset_b_o) |-> !gclk0_o)
    else $error("generator zero ran while the chip was held in reset");
  gclk_mask_a: assert property (cpu_reset_b_o |-> gclk_enable_o == 8'h05)
    else $error("wrong generic clock enables after start-up");
  core_bod_a: assert property (core_supply_brownout_detector_en_o == cpu_reset_b_o)
    else $error("core brown-out supervision out of step with start-up");
  load_done_a: assert property (user_row_rd_req_o && user_row_rd_ack_i && supply_stable_i
    |=> cpu_reset_b_o && !user_row_rd_req_o)
    else $error("row answer did not release the cpu");
  cfg_hold_a: assert property (cpu_reset_b_o && $past(cpu_reset_b_o) |-> $stable(flash_cfg_o))
    else $error("flash settings changed while running");
  row_low_a: assert property (bus_rd_i && bus_addr_i == 32'h0080_4000
    |=> bus_rd_data_o == row_ff[31:0])
    else $error("wrong low row word on the bus");
  row_high_a: assert property (bus_rd_i && bus_addr_i == 32'h0080_4004
    |=> bus_rd_data_o == row_ff[63:32])
    else $error("wrong high row word on the bus");
endmodule
bind power_up_config_loader power_up_config_loader_checker i_power_up_config_loader_checker (
  .ref_clk_i, .rst_b_i, .supply_stable_i, .main_supply_below_threshold_i, .user_row_rd_req_o,
  .user_row_rd_ack_i, .user_row_rd_data_i, .bus_addr_i, .bus_rd_i, .bus_rd_data_o,
  .chip_reset_b_o, .cpu_reset_b_o, .gclk_enable_o, .gclk0_o, .power_manager_unit_clk_o,
  .core_supply_brownout_detector_en_o, .flash_cfg_o);
`default_nettype wire

// [dv/test_power_up_config_loader.sv]
// Self-checking bench for the power-up sequencer and configuration loader.
`timescale 1ns/10ps
`default_nettype none
module test_power_up_config_loader;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic osc = 1'b0;
  logic stable = 1'b0;
  logic below = 1'b0;
  logic rd = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [63:0] row = 64'h0;
  logic [3:0] dly = 4'h0;
  logic req, ack, chip_b, cpu_b, done, g0, mgr_clk, cbod_en;
  logic [31:0] rdata, pc, pages, pbytes;
  logic [2:0] region;
  logic [7:0] gen;
  logic [3:0] sdiv;
  logic [15:0] pad_oe;
  logic [21:0] fcfg;
  logic [9:0] mcfg;
  logic [14:0] wcfg;
  logic [8:0] ccfg;
  int n_mismatch = 0;
  int n_tests = 0;
  int oc = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  // Oscillator stand-in with a twelve cycle period, moved on falling edges.
  always @(negedge ref_clk_i) begin
    oc <= (oc == 5) ? 0 : oc + 1;
    osc <= (oc == 5) ? ~osc : osc;
  end
  power_up_config_loader i_power_up_config_loader (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .internal_8mhz_oscillator_i(osc), .supply_stable_i(stable),
    .main_supply_below_threshold_i(below), .user_row_rd_req_o(req), .user_row_rd_ack_i(ack),
    .user_row_rd_data_i(row), .bus_addr_i(addr), .bus_rd_i(rd), .bus_rd_data_o(rdata),
    .bus_region_o(region), .chip_reset_b_o(chip_b), .cpu_reset_b_o(cpu_b),
    .cpu_reset_addr_o(pc), .gclk0_o(g0), .gclk_enable_o(gen), .power_manager_unit_clk_o(mgr_clk),
    .sys_clk_div_o(sdiv), .pad_oe_o(pad_oe), .core_supply_brownout_detector_en_o(cbod_en),
    .startup_done_o(done), .flash_cfg_o(fcfg), .mbod_cfg_o(mcfg), .watchdog_cfg_o(wcfg),
    .cbod_cfg_o(ccfg), .flash_pages_o(pages), .flash_page_bytes_o(pbytes));
  user_row_store i_user_row_store (.ref_clk_i(ref_clk_i), .req_i(req), .dly_i(dly), .ack_o(ack));
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_cfg(input logic [63:0] r);
    chk("flash cfg", {42'h0, r[2:0], r[6:4], r[63:48]}, {42'h0, fcfg});
    chk("main bod cfg", {54'h0, r[13:8], r[14], r[16:15], r[40]}, {54'h0, mcfg});
    chk("watchdog cfg", {49'h0, r[25], r[26], r[39], r[30:27], r[34:31], r[38:35]},
      {49'h0, wcfg});
    chk("core bod cfg", {55'h0, r[24:17], r[41]}, {55'h0, ccfg});
  endtask
  task automatic wait_run();
    int k;
    k = 0;
    while (cpu_b !== 1'b1 && k < 40) begin
      @(negedge ref_clk_i);
      k++;
    end
    chk("cpu release", 64'h1, {63'h0, cpu_b});
    chk("startup done", 64'h1, {63'h0, done});
  endtask
  // Resets with the supply unstable, then lets the sequence load row r.
  task automatic boot(input logic [63:0] r, input logic [3:0] d);
    @(negedge ref_clk_i);
    rst_b_i = 1'b0;
    stable = 1'b0;
    row = r;
    dly = d;
    repeat (3) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk("held reset", 64'h0, {62'h0, cpu_b, chip_b});
    chk("pads", 64'h0, {48'h0, pad_oe});
    stable = 1'b1;
    wait_run();
    chk_cfg(r);
    chk("fetch address", 64'h0, {32'h0, pc});
    chk("sys divider", 64'h1, {60'h0, sdiv});
    chk("clock enables", 64'h5, {56'h0, gen});
    chk("core bod on", 64'h1, {63'h0, cbod_en});
    chk("flash geometry", {32'h100, 32'h40}, {pages, pbytes});
  endtask
  task automatic rd32(input logic [31:0] a, input logic [31:0] e);
    @(negedge ref_clk_i);
    addr = a;
    rd = 1'b1;
    @(negedge ref_clk_i);
    rd = 1'b0;
    chk("bus read", {32'h0, e}, {32'h0, rdata});
  endtask
  // Row words over the bus, then the region of five bases, both sides of the bridge A end and one unmapped address.
  task automatic t_bus();
    logic [31:0] amap [8] = '{32'h0, 32'h2000_0000, 32'h4000_ffff, 32'h4100_0000,
      32'h4200_0000, 32'h0080_4000, 32'h4001_0000, 32'h6000_0000};
    logic [2:0] rmap [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6};
    rd32(32'h0080_4000, row[31:0]);
    rd32(32'h0080_4004, row[63:32]);
    rd32(32'h0080_4008, 32'h0);
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk_i);
      addr = amap[i];
      #1;
      chk("region", {61'h0, rmap[i]}, {61'h0, region});
    end
  endtask
  task automatic wlev(input logic v, output int n);
    n = 0;
    while (g0 !== v && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
  endtask
  // One generator zero period is eight oscillator periods of twelve cycles.
  task automatic t_div();
    int n;
    int h;
    int l;
    wlev(1'b0, n);
    wlev(1'b1, n);
    wlev(1'b0, h);
    wlev(1'b1, l);
    chk("gclk0 period", 64'h60, 64'(h + l));
    chk("manager clock", {63'h0, g0}, {63'h0, mgr_clk});
  endtask
  // Rewrites the row keeping the factory core bits; the old value stays until reset.
  task automatic t_reload();
    logic [63:0] old;
    logic [63:0] keep;
    old = row;
    keep = 64'h0000_0200_01fe_0000;
    @(negedge ref_clk_i);
    row = (~old & ~keep) | (old & keep);
    repeat (5) @(negedge ref_clk_i);
    chk_cfg(old);
    boot(row, 4'h3);
  endtask
  task automatic t_por();
    @(negedge ref_clk_i);
    below = 1'b1;
    @(negedge ref_clk_i);
    chk("supply reset", 64'h0, {62'h0, chip_b, cpu_b});
    below = 1'b0;
    wait_run();
    chk_cfg(row);
  endtask
  // Main sequence.
  initial begin
    boot(64'ha5c3_96f0_1e2d_3c4b, 4'h0);
    t_bus();
    t_div();
    boot(64'h5a3c_690f_e1d2_c3b4, 4'h5);
    t_reload();
    t_por();
    wrap_up();
  end
  // Cuts a hang short well after the expected few hundred cycles.
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire
